/* pkg/prog_port_regs.svh */
// constants of the parallel programming port
// How it works
// - flash written by pages; low address bits pick the word, upper bits the page
// - eeprom written by pages; low address bits pick the byte, upper bits the page
// - each rising load strobe performs the action chosen by the two action pins
// - action 00 loads an address byte; byte selects pick low, high or extended
// - action 01 loads a data byte; low byte select picks low or high byte
// - write or read-enable strobe performs the most recently loaded command
// - write commands: 80 erase, 40 fuses, 20 lock, 10 flash, 11 eeprom
// - read commands: 08 signature, 04 fuses and lock, 02 flash, 03 eeprom
// - done flag low while programming, high while idle and ready to accept a new command
// - data bus is input except while read enable is low, then device drives it
// - falling write strobe starts the loaded write-type operation
// - rising page latch strobe moves loaded data into the page buffer
// - byte select 00 low, 01 high, 10 extended; reserved codes elsewhere
// - fuse read: 00 fuse low, 01 lock, 10 extended fuse, 11 fuse high
// - command and address bytes kept across operations until reloaded
`ifndef PROG_PORT_REGS_SVH
`define PROG_PORT_REGS_SVH

// ==========================================================
// load actions and byte selects
`define ACT_ADDR 2'b00
`define ACT_DATA 2'b01
`define ACT_CMD 2'b10
`define ACT_IDLE 2'b11
`define BSEL_LOW 2'b00
`define BSEL_HIGH 2'b01
`define BSEL_EXT 2'b10
`define BSEL_RSVD 2'b11

// ==========================================================
// command bytes
`define CMD_NOP 8'h00
`define CMD_ERASE 8'h80
`define CMD_WFUSE 8'h40
`define CMD_WLOCK 8'h20
`define CMD_WFLASH 8'h10
`define CMD_WEE 8'h11
`define CMD_RSIG 8'h08
`define CMD_RFUSE 8'h04
`define CMD_RFLASH 8'h02
`define CMD_REE 8'h03

// ==========================================================
// reset values and fields
`define FUSE_LO_RST 8'h62
`define FUSE_HI_RST 8'h99
`define FUSE_EXT_RST 8'hff
`define LOCK_RST 8'hff
`define EESAVE_BIT 3
`define ERASED_WORD 16'hffff
`define ERASED_BYTE 8'hff

// ==========================================================
// timing of the programmer side
`define CLOCK_HZ 20000000
`define STROBE_MIN_NS 250
`define STROBE_MIN_CYC ((`STROBE_MIN_NS * (`CLOCK_HZ / 1000000) + 999) / 1000)
`define ENTRY_SETUP_NS 100
`define ENTRY_WAIT_US 50
`define ENTRY_WAIT_CYC (`ENTRY_WAIT_US * (`CLOCK_HZ / 1000000))

`endif

/* pkg/prog_port_pkg.sv */
// types of the parallel programming port
`default_nettype none
package prog_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SWEEP = 2'b01,
    ST_WAIT = 2'b10
  } st_e;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ERASE = 2'b01,
    OP_FLASH = 2'b10,
    OP_EE = 2'b11
  } op_e;

  // programmer-driven pins, sampled on clock
  typedef struct packed {
    logic load_strobe;
    logic load_action_bit1;
    logic load_action_bit0;
    logic byte_sel_upper;
    logic byte_sel_low;
    logic page_latch_strobe;
    logic wr_n;
    logic oe_n;
    logic [7:0] data_in;
  } pins_s;

  typedef struct packed {
    st_e state;
    op_e op;
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] addr_ext;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
    logic [7:0] lock;
    logic [7:0] rdata;
    logic load_prev;
    logic wr_prev;
    logic pl_prev;
    logic [15:0] idx;
    logic [15:0] limit;
  } port_state_s;

  typedef struct packed {
    logic run;
    logic done;
    logic [15:0] count;
  } timer_s;

endpackage : prog_port_pkg
`default_nettype wire

/* hdl/prog_timer.sv */
// programming-time counter: one done pulse a fixed number of cycles after start
`default_nettype none
module prog_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control
  input wire logic start,
  output logic done
);

  prog_port_pkg::timer_s t_reg;
  prog_port_pkg::timer_s t_next;

  if (CYCLES < 1 || CYCLES > 65535) begin : g_bad
    $error("prog_timer: CYCLES out of range");
  end

  always_comb begin
    t_next = t_reg;
    t_next.done = 1'b0;
    if (start) begin
      t_next.run = 1'b1;
      t_next.count = 16'(CYCLES - 1);
    end else if (t_reg.run) begin
      if (t_reg.count == 16'h0000) begin
        t_next.run = 1'b0;
        t_next.done = 1'b1;
      end else begin
        t_next.count = t_reg.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      t_reg <= '{run: 1'b0, done: 1'b0, count: 16'h0000};
    end else begin
      t_reg <= t_next;
    end
  end

  assign done = t_reg.done;

endmodule : prog_timer
`default_nettype wire

/* hdl/parallel_program_port.sv */
// parallel programming port: command, address and data loading, page writes, reads
`default_nettype none
`include "prog_port_regs.svh"
module parallel_program_port #(
  parameter int unsigned FLASH_TOP = 14,
  parameter int unsigned FLASH_PAGE_BITS = 7,
  parameter int unsigned EE_TOP = 10,
  parameter int unsigned EE_PAGE_BITS = 3,
  parameter int unsigned PROG_CYCLES = 16,
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // arbitrary
  parameter logic [7:0] SIG_BYTE2 = 8'h21, // arbitrary
  parameter logic [7:0] CAL_BYTE = 8'h80 // arbitrary
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // programmer pins
  input wire prog_port_pkg::pins_s pins,
  // data bus drive
  output logic [7:0] data_out,
  output logic data_oe,
  // status
  output logic op_done_flag
);

  localparam int unsigned FA_W = FLASH_TOP + 1;
  localparam int unsigned EA_W = EE_TOP + 1;
  localparam int unsigned FLASH_DEPTH = 1 << FA_W;
  localparam int unsigned EE_DEPTH = 1 << EA_W;
  localparam int unsigned FPAGE = 1 << FLASH_PAGE_BITS;
  localparam int unsigned EPAGE = 1 << EE_PAGE_BITS;

  if (FLASH_TOP > 15 || EE_TOP > 15 || FLASH_PAGE_BITS >= FA_W
      || EE_PAGE_BITS >= EA_W || FLASH_PAGE_BITS < 1 || EE_PAGE_BITS < 1) begin : g_bad
    $error("parallel_program_port: address widths out of range");
  end

  // ==========================================================
  // state and memories
  prog_port_pkg::port_state_s s_reg;
  prog_port_pkg::port_state_s s_next;
  logic [15:0] flash_mem [FLASH_DEPTH];
  logic [7:0] ee_mem [EE_DEPTH];
  logic [15:0] fbuf [FPAGE];
  logic [7:0] ebuf [EPAGE];

  localparam prog_port_pkg::port_state_s RST = '{
    state: prog_port_pkg::ST_IDLE, op: prog_port_pkg::OP_NONE,
    cmd: `CMD_NOP, addr_lo: 8'h00, addr_hi: 8'h00, addr_ext: 8'h00,
    data_lo: 8'h00, data_hi: 8'h00, fuse_lo: `FUSE_LO_RST, fuse_hi: `FUSE_HI_RST,
    fuse_ext: `FUSE_EXT_RST, lock: `LOCK_RST, rdata: 8'h00,
    load_prev: 1'b0, wr_prev: 1'b1, pl_prev: 1'b0, idx: 16'h0000, limit: 16'h0000};

  // ==========================================================
  // address forming
  function automatic logic [FA_W-1:0] flash_addr(input logic [7:0] ext,
                                                 input logic [7:0] hi,
                                                 input logic [7:0] lo);
    logic [23:0] full;
    full = {ext, hi, lo};
    return full[FA_W-1:0];
  endfunction : flash_addr

  function automatic logic [EA_W-1:0] ee_addr(input logic [7:0] hi,
                                              input logic [7:0] lo);
    logic [15:0] full;
    full = {hi, lo};
    return full[EA_W-1:0];
  endfunction : ee_addr

  logic [FA_W-1:0] faddr;
  logic [EA_W-1:0] eaddr;
  logic [FA_W-1:0] fsweep;
  logic [EA_W-1:0] esweep;
  logic [1:0] action;
  logic [1:0] bsel;
  logic load_rise;
  logic wr_fall;
  logic pl_rise;
  logic is_idle;
  logic timer_start;
  logic timer_done;

  assign faddr = flash_addr(s_reg.addr_ext, s_reg.addr_hi, s_reg.addr_lo);
  assign eaddr = ee_addr(s_reg.addr_hi, s_reg.addr_lo);
  // page from the loaded address, word from the sweep index
  assign fsweep = {faddr[FA_W-1:FLASH_PAGE_BITS], s_reg.idx[FLASH_PAGE_BITS-1:0]};
  assign esweep = {eaddr[EA_W-1:EE_PAGE_BITS], s_reg.idx[EE_PAGE_BITS-1:0]};
  assign action = {pins.load_action_bit1, pins.load_action_bit0};
  assign bsel = {pins.byte_sel_upper, pins.byte_sel_low};
  assign load_rise = pins.load_strobe & ~s_reg.load_prev;
  assign wr_fall = ~pins.wr_n & s_reg.wr_prev;
  assign pl_rise = pins.page_latch_strobe & ~s_reg.pl_prev;
  assign is_idle = (s_reg.state == prog_port_pkg::ST_IDLE);

  // ==========================================================
  // next state
  always_comb begin
    s_next = s_reg;
    timer_start = 1'b0;
    s_next.load_prev = pins.load_strobe;
    s_next.wr_prev = pins.wr_n;
    s_next.pl_prev = pins.page_latch_strobe;
    // loaded bytes persist until the programmer reloads them
    if (load_rise) begin
      unique case (action)
        `ACT_ADDR: begin
          unique case (bsel)
            `BSEL_LOW: s_next.addr_lo = pins.data_in;
            `BSEL_HIGH: s_next.addr_hi = pins.data_in;
            `BSEL_EXT: s_next.addr_ext = pins.data_in;
            `BSEL_RSVD: ;
          endcase
        end
        `ACT_DATA: begin
          if (pins.byte_sel_low) begin
            s_next.data_hi = pins.data_in;
          end else begin
            s_next.data_lo = pins.data_in;
          end
        end
        `ACT_CMD: s_next.cmd = pins.data_in;
        `ACT_IDLE: ;
      endcase
    end
    unique case (s_reg.state)
      prog_port_pkg::ST_IDLE: begin
        if (wr_fall) begin
          s_next.idx = 16'h0000;
          case (s_reg.cmd)
            `CMD_ERASE: begin
              s_next.op = prog_port_pkg::OP_ERASE;
              s_next.limit = 16'(FLASH_DEPTH - 1);
              s_next.state = prog_port_pkg::ST_SWEEP;
            end
            `CMD_WFLASH: begin
              s_next.op = prog_port_pkg::OP_FLASH;
              s_next.limit = 16'(FPAGE - 1);
              s_next.state = prog_port_pkg::ST_SWEEP;
            end
            `CMD_WEE: begin
              s_next.op = prog_port_pkg::OP_EE;
              s_next.limit = 16'(EPAGE - 1);
              s_next.state = prog_port_pkg::ST_SWEEP;
            end
            `CMD_WFUSE: begin
              // fuse value always comes from the data low byte
              unique case (bsel)
                `BSEL_LOW: s_next.fuse_lo = s_reg.data_lo;
                `BSEL_HIGH: s_next.fuse_hi = s_reg.data_lo;
                `BSEL_EXT: s_next.fuse_ext = s_reg.data_lo;
                `BSEL_RSVD: ;
              endcase
              if (bsel != `BSEL_RSVD) begin
                s_next.state = prog_port_pkg::ST_WAIT;
                timer_start = 1'b1;
              end
            end
            `CMD_WLOCK: begin
              // lock bits only get programmed here; erase is the way back
              s_next.lock = s_reg.lock & s_reg.data_lo;
              s_next.state = prog_port_pkg::ST_WAIT;
              timer_start = 1'b1;
            end
            default: ;
          endcase
        end
      end
      prog_port_pkg::ST_SWEEP: begin
        if (s_reg.idx == s_reg.limit) begin
          if (s_reg.op == prog_port_pkg::OP_ERASE) begin
            s_next.lock = `LOCK_RST;
          end
          s_next.state = prog_port_pkg::ST_WAIT;
          timer_start = 1'b1;
        end else begin
          s_next.idx = s_reg.idx + 16'h0001;
        end
      end
      prog_port_pkg::ST_WAIT: begin
        if (timer_done) begin
          s_next.state = prog_port_pkg::ST_IDLE;
          s_next.op = prog_port_pkg::OP_NONE;
        end
      end
      default: s_next.state = prog_port_pkg::ST_IDLE;
    endcase
    // read data follows command and byte selects one cycle later
    case (s_reg.cmd)
      `CMD_RSIG: begin
        if (pins.byte_sel_low) begin
          s_next.rdata = CAL_BYTE;
        end else begin
          unique case (s_reg.addr_lo[1:0])
            2'b00: s_next.rdata = SIG_BYTE0;
            2'b01: s_next.rdata = SIG_BYTE1;
            2'b10: s_next.rdata = SIG_BYTE2;
            2'b11: s_next.rdata = `ERASED_BYTE;
          endcase
        end
      end
      `CMD_RFUSE: begin
        unique case (bsel)
          2'b00: s_next.rdata = s_reg.fuse_lo;
          2'b01: s_next.rdata = s_reg.lock;
          2'b10: s_next.rdata = s_reg.fuse_ext;
          2'b11: s_next.rdata = s_reg.fuse_hi;
        endcase
      end
      `CMD_RFLASH: begin
        s_next.rdata = pins.byte_sel_low ? flash_mem[faddr][15:8] : flash_mem[faddr][7:0];
      end
      `CMD_REE: s_next.rdata = ee_mem[eaddr];
      default: s_next.rdata = `ERASED_BYTE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_reg <= RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // page buffers and arrays
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < FPAGE; i++) begin
        fbuf[i] <= `ERASED_WORD;
      end
      for (int i = 0; i < EPAGE; i++) begin
        ebuf[i] <= `ERASED_BYTE;
      end
    end else begin
      // latching is held off while a page is being committed
      if (pl_rise && is_idle && s_reg.cmd == `CMD_WFLASH) begin
        fbuf[faddr[FLASH_PAGE_BITS-1:0]] <= {s_reg.data_hi, s_reg.data_lo};
      end
      if (pl_rise && is_idle && s_reg.cmd == `CMD_WEE) begin
        ebuf[eaddr[EE_PAGE_BITS-1:0]] <= s_reg.data_lo;
      end
      if (s_reg.state == prog_port_pkg::ST_SWEEP) begin
        unique case (s_reg.op)
          prog_port_pkg::OP_ERASE: begin
            flash_mem[s_reg.idx[FA_W-1:0]] <= `ERASED_WORD;
            if ({16'h0000, s_reg.idx} < 32'(EE_DEPTH) && s_reg.fuse_hi[`EESAVE_BIT]) begin
              ee_mem[s_reg.idx[EA_W-1:0]] <= `ERASED_BYTE;
            end
          end
          prog_port_pkg::OP_FLASH: begin
            flash_mem[fsweep] <= fbuf[s_reg.idx[FLASH_PAGE_BITS-1:0]];
            fbuf[s_reg.idx[FLASH_PAGE_BITS-1:0]] <= `ERASED_WORD;
          end
          prog_port_pkg::OP_EE: begin
            ee_mem[esweep] <= ebuf[s_reg.idx[EE_PAGE_BITS-1:0]];
            ebuf[s_reg.idx[EE_PAGE_BITS-1:0]] <= `ERASED_BYTE;
          end
          prog_port_pkg::OP_NONE: ;
        endcase
      end
    end
  end

  prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clock(clock),
    .srst(srst),
    .start(timer_start),
    .done(timer_done)
  );

  // ==========================================================
  // outputs
  assign op_done_flag = is_idle;
  assign data_oe = ~pins.oe_n;
  assign data_out = s_reg.rdata;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  cmd_load_a: assert property (load_rise && action == `ACT_CMD |=> s_reg.cmd == $past(pins.data_in)) else $error("command byte not captured");
  idle_action_a: assert property (load_rise && action == `ACT_IDLE |=> $stable(s_reg.cmd) && $stable(s_reg.addr_lo) && $stable(s_reg.data_lo)) else $error("idle action changed state");
  addr_high_a: assert property (load_rise && action == `ACT_ADDR && bsel == `BSEL_HIGH |=> s_reg.addr_hi == $past(pins.data_in)) else $error("address high byte not captured");
  data_high_a: assert property (load_rise && action == `ACT_DATA && pins.byte_sel_low |=> s_reg.data_hi == $past(pins.data_in) && $stable(s_reg.data_lo)) else $error("data high byte wrong");
  addr_hold_a: assert property (!load_rise |=> $stable({s_reg.cmd, s_reg.addr_lo, s_reg.addr_hi, s_reg.addr_ext})) else $error("loaded bytes changed without load");
  // shortest legal page commit: two words swept, one program cycle, one done cycle
  page_busy_a: assert property (is_idle && wr_fall && s_reg.cmd == `CMD_WFLASH |=> !op_done_flag [*4]) else $error("flash page write not busy");
  fuse_write_a: assert property (is_idle && wr_fall && s_reg.cmd == `CMD_WFUSE && bsel == `BSEL_LOW |=> s_reg.fuse_lo == $past(s_reg.data_lo) && !op_done_flag) else $error("fuse low not written");
  rsvd_fuse_a: assert property (is_idle && wr_fall && s_reg.cmd == `CMD_WFUSE && bsel == `BSEL_RSVD |=> op_done_flag && $stable({s_reg.fuse_lo, s_reg.fuse_hi, s_reg.fuse_ext})) else $error("reserved select changed fuses");
  lock_read_a: assert property (s_reg.cmd == `CMD_RFUSE && bsel == 2'b01 && $stable(s_reg.lock) |=> data_out == $past(s_reg.lock)) else $error("lock read wrong");
  // busy watch: a whole-flash erase sweep plus the program wait is the longest busy run
  localparam int unsigned BUSY_MAX = FLASH_DEPTH + PROG_CYCLES + 1;
  logic [31:0] busy_cnt;
  always_ff @(posedge clock) begin
    if (srst || is_idle) begin
      busy_cnt <= 32'h0000_0000;
    end else begin
      busy_cnt <= busy_cnt + 32'h0000_0001;
    end
  end
  busy_len_a: assert property (busy_cnt <= BUSY_MAX) else $error("busy never ended");
  bus_drive_a: assert property (pins.oe_n |-> !data_oe) else $error("bus driven without read enable");

  erase_c: cover property (is_idle && wr_fall && s_reg.cmd == `CMD_ERASE);
  flash_page_c: cover property (s_reg.op == prog_port_pkg::OP_FLASH ##1 op_done_flag);
  ee_page_c: cover property (s_reg.op == prog_port_pkg::OP_EE ##1 op_done_flag);
  fuse_read_c: cover property (s_reg.cmd == `CMD_RFUSE && data_oe);

endmodule : parallel_program_port
`default_nettype wire

/* dv/programmer_model.sv */
// behavioural external programmer driving the parallel programming pins
`default_nettype none
module programmer_model #(
  parameter int unsigned HOLD = 5
) (
  // clock
  input wire logic clock,
  // pins towards the device
  output var prog_port_pkg::pins_s pins,
  // device side of the data bus and status
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic op_done_flag
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // pin state, entry pattern at start
  logic load_strobe = 1'b0;
  logic [1:0] act = 2'b00;
  logic [1:0] bsel = 2'b00;
  logic page_latch_strobe = 1'b0;
  logic wr_n = 1'b1;
  logic oe_n = 1'b1;
  logic drv_en = 1'b1;
  logic [7:0] drv = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] bus;

  // no pull on the bus: a floating line shows the inverse of its last level
  assign bus = data_oe ? data_out : (drv_en ? drv : ~last);
  always_ff @(posedge clock) last <= bus;
  assign pins = {load_strobe, act, bsel, page_latch_strobe, wr_n, oe_n, bus};

  // ==========================================================
  // strobe tasks, each pulse held for the minimum width
  task automatic load(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    @(negedge clock);
    act = a;
    bsel = b;
    drv = d;
    load_strobe = 1'b1;
    repeat (HOLD) @(negedge clock);
    load_strobe = 1'b0;
  endtask : load

  task automatic latch();
    @(negedge clock);
    page_latch_strobe = 1'b1;
    repeat (HOLD) @(negedge clock);
    page_latch_strobe = 1'b0;
  endtask : latch

  task automatic write(input logic [1:0] b, output logic busy_seen, output logic ready_ok);
    busy_seen = 1'b0;
    ready_ok = 1'b0;
    @(negedge clock);
    bsel = b;
    wr_n = 1'b0;
    repeat (HOLD) begin
      @(negedge clock);
      if (op_done_flag === 1'b0) busy_seen = 1'b1;
    end
    wr_n = 1'b1;
    // next command only once ready again
    for (int i = 0; i < 2000 && !ready_ok; i++) begin
      @(negedge clock);
      if (op_done_flag === 1'b0) busy_seen = 1'b1;
      else if (op_done_flag === 1'b1) ready_ok = 1'b1;
    end
  endtask : write

  task automatic read(input logic [1:0] b, output logic [7:0] d, output logic oe_seen);
    @(negedge clock);
    bsel = b;
    drv_en = 1'b0;
    oe_n = 1'b0;
    repeat (HOLD) @(negedge clock);
    d = bus;
    oe_seen = data_oe;
    oe_n = 1'b1;
    @(negedge clock);
    drv_en = 1'b1;
  endtask : read
endmodule : programmer_model
`default_nettype wire

/* dv/parallel_program_port_test.sv */
// self-checking bench of the parallel programming port
`default_nettype none
`include "prog_port_regs.svh"
`define CHECK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end
module parallel_program_port_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // identity bytes, values arbitrary
  localparam logic [7:0] SIG0 = 8'h6b;
  localparam logic [7:0] SIG1 = 8'h4d;
  localparam logic [7:0] SIG2 = 8'h17;
  localparam logic [7:0] CAL = 8'h9e;

  typedef struct packed {
    logic [7:0] cmd;
    logic [1:0] bsel;
    logic [7:0] addr;
    logic [7:0] exp;
  } read_row_s;

  read_row_s rows [10] = '{
    '{`CMD_RFUSE, 2'b00, 8'h00, `FUSE_LO_RST},
    '{`CMD_RFUSE, 2'b01, 8'h00, `LOCK_RST},
    '{`CMD_RFUSE, 2'b10, 8'h00, `FUSE_EXT_RST},
    '{`CMD_RFUSE, 2'b11, 8'h00, `FUSE_HI_RST},
    '{`CMD_RSIG, 2'b00, 8'h00, SIG0},
    '{`CMD_RSIG, 2'b00, 8'h01, SIG1},
    '{`CMD_RSIG, 2'b00, 8'h02, SIG2},
    '{`CMD_RSIG, 2'b00, 8'h03, 8'hff},
    '{`CMD_RSIG, 2'b01, 8'h00, CAL},
    '{8'h5a, 2'b00, 8'h00, 8'hff}
  };

  logic clock = 1'b0;
  logic srst = 1'b1;
  prog_port_pkg::pins_s pins;
  logic [7:0] data_out;
  logic data_oe;
  logic op_done_flag;
  logic [7:0] rd;
  logic busy;
  int tests_run = 0;
  int miscompares = 0;

  always #25 clock = ~clock;

  // short counts keep erase sweeps and program waits brief
  parallel_program_port #(
    .FLASH_TOP(8), .FLASH_PAGE_BITS(2), .EE_TOP(4), .EE_PAGE_BITS(1), .PROG_CYCLES(2),
    .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)
  ) parallel_program_port_inst (
    .clock(clock), .srst(srst), .pins(pins),
    .data_out(data_out), .data_oe(data_oe), .op_done_flag(op_done_flag)
  );

  programmer_model programmer_model_inst (
    .clock(clock), .pins(pins),
    .data_out(data_out), .data_oe(data_oe), .op_done_flag(op_done_flag)
  );

  // ==========================================================
  // helpers
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic ld(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    programmer_model_inst.load(a, b, d);
  endtask : ld

  task automatic wr(input logic [1:0] b);
    logic ok;
    programmer_model_inst.write(b, busy, ok);
    if (!ok) begin
      miscompares++;
      $display("ERROR op_done_flag expected 1 seen 0");
      summarize();
    end
  endtask : wr

  task automatic rdchk(input logic [1:0] b, input logic [7:0] exp, input string what);
    logic oe;
    programmer_model_inst.read(b, rd, oe);
    `CHECK(what, 1'b1, oe)
    `CHECK(what, exp, rd)
  endtask : rdchk

  // ==========================================================
  // sequence
  initial begin
    repeat (20) @(negedge clock);
    srst = 1'b0;
    // settle time after entry before the first command
    repeat (`ENTRY_WAIT_CYC) @(negedge clock);
    foreach (rows[i]) begin
      ld(`ACT_CMD, 2'b00, rows[i].cmd);
      ld(`ACT_ADDR, `BSEL_LOW, rows[i].addr);
      rdchk(rows[i].bsel, rows[i].exp, "read row");
    end
    $display("test read table done");
    ld(`ACT_CMD, 2'b00, `CMD_ERASE);
    wr(2'b00);
    `CHECK("erase busy", 1'b1, busy)
    $display("test erase done");
    ld(`ACT_CMD, 2'b00, `CMD_WFLASH);
    ld(`ACT_ADDR, `BSEL_EXT, 8'h00);
    ld(`ACT_ADDR, `BSEL_HIGH, 8'h00);
    ld(`ACT_ADDR, `BSEL_LOW, 8'h05);
    ld(`ACT_DATA, 2'b00, 8'ha5);
    ld(`ACT_DATA, 2'b01, 8'h3c);
    programmer_model_inst.latch();
    // word bits changed before commit: only the page bits may count
    ld(`ACT_ADDR, `BSEL_LOW, 8'h07);
    wr(2'b00);
    `CHECK("flash busy", 1'b1, busy)
    ld(`ACT_CMD, 2'b00, `CMD_RFLASH);
    ld(`ACT_ADDR, `BSEL_LOW, 8'h05);
    rdchk(2'b00, 8'ha5, "flash low");
    rdchk(2'b01, 8'h3c, "flash high");
    ld(`ACT_ADDR, `BSEL_LOW, 8'h07);
    rdchk(2'b00, 8'hff, "flash other word");
    $display("test flash page done");
    ld(`ACT_CMD, 2'b00, `CMD_WEE);
    ld(`ACT_ADDR, `BSEL_LOW, 8'h03);
    ld(`ACT_DATA, 2'b00, 8'h77);
    programmer_model_inst.latch();
    wr(2'b00);
    `CHECK("eeprom busy", 1'b1, busy)
    ld(`ACT_CMD, 2'b00, `CMD_REE);
    rdchk(2'b00, 8'h77, "eeprom byte");
    ld(`ACT_ADDR, `BSEL_LOW, 8'h02);
    rdchk(2'b00, 8'hff, "eeprom neighbour");
    $display("test eeprom page done");
    ld(`ACT_CMD, 2'b00, `CMD_WFUSE);
    for (int k = 0; k < 3; k++) begin
      ld(`ACT_DATA, 2'b00, 8'h20 + 8'(k));
      wr(2'(k));
      `CHECK("fuse busy", 1'b1, busy)
    end
    ld(`ACT_DATA, 2'b00, 8'h55);
    wr(`BSEL_RSVD);
    `CHECK("reserved fuse busy", 1'b0, busy)
    ld(`ACT_CMD, 2'b00, `CMD_WLOCK);
    ld(`ACT_DATA, 2'b00, 8'hf0);
    wr(2'b00);
    `CHECK("lock busy", 1'b1, busy)
    ld(`ACT_CMD, 2'b00, `CMD_RFUSE);
    ld(`ACT_IDLE, 2'b00, `CMD_RFLASH);
    rdchk(2'b00, 8'h20, "fuse low");
    rdchk(2'b11, 8'h21, "fuse high");
    rdchk(2'b10, 8'h22, "fuse ext");
    rdchk(2'b01, 8'hf0, "lock");
    $display("test fuse and lock done");
    ld(`ACT_CMD, 2'b00, 8'h5a);
    wr(2'b00);
    `CHECK("unknown busy", 1'b0, busy)
    rdchk(2'b00, 8'hff, "unknown read");
    $display("test unknown command done");
    @(negedge clock);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    `CHECK("ready after reset", 1'b1, op_done_flag)
    `CHECK("bus released", 1'b0, data_oe)
    ld(`ACT_CMD, 2'b00, `CMD_RFUSE);
    rdchk(2'b11, `FUSE_HI_RST, "fuse high reset");
    $display("test mid-run reset done");
    summarize();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    $display("ERROR run length expected 20000 seen 20000");
    summarize();
  end
endmodule : parallel_program_port_test
`default_nettype wire
